// file: rtl/mopc_params.svh
// constants for the masked output pin control block
`ifndef MOPC_PARAMS_SVH
`define MOPC_PARAMS_SVH
`define MOPC_LINES          20
`define MOPC_GROUP_LINES    10
`define MOPC_CFG_OUT_LOW    3'h4
`define MOPC_CFG_OUT_HIGH   3'h5
`define MOPC_CFG_DISABLED   3'h0
`define MOPC_HOLD_MAX       13'h1770
`define MOPC_TICK_MS        100
`define MOPC_CLK_HZ         50000000
`define MOPC_TICK_CYCLES    ((`MOPC_CLK_HZ / 1000) * `MOPC_TICK_MS)
`define MOPC_LEVELS_RST     20'h0_0000
`endif

// file: rtl/mopc_pkg.sv
// types for the masked output pin control block
package mopc_pkg;
  typedef logic [2:0]  mopc_cfg_t;
  typedef logic [12:0] mopc_hold_t;
  typedef struct packed {
    logic [19:0] levels;
    logic [19:0] mask;
  } mopc_cmd_s;
  typedef enum logic [1:0] {
    MOPC_SMP_IDLE   = 2'b00,
    MOPC_SMP_ACTIVE = 2'b01
  } mopc_smp_e;
endpackage : mopc_pkg

// file: rtl/mopc_top.sv
// masked output pin control: level commands, hold timers, sample routing
`timescale 1ns/10ps
`include "mopc_params.svh"
module mopc_top
  import mopc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MOPC_TICK_CYCLES
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rstn,
  // line configuration, one code per line
  input  wire mopc_cfg_t         i_line_cfg [`MOPC_LINES],
  input  wire logic              i_cfg_we,
  // hold settings, low group lines 0-9, high group lines 10-19
  input  wire mopc_hold_t        i_hold_timer_low_group  [`MOPC_GROUP_LINES],
  input  wire mopc_hold_t        i_hold_timer_high_group [`MOPC_GROUP_LINES],
  // write-levels command
  input  wire logic              i_cmd_valid,
  input  wire mopc_cmd_s         i_cmd,
  // sampling setup
  input  wire logic [15:0]       i_sample_rate_setting,
  input  wire logic              i_mgmt_enable,
  // line outputs
  output logic [`MOPC_LINES-1:0] o_line_level,
  output logic [`MOPC_LINES-1:0] o_line_oe,
  // sample routing status
  output logic                   o_sample_enable,
  output logic                   o_sample_to_mgmt,
  output logic                   o_sample_to_dest
);

  mopc_cfg_t                cfg_r [`MOPC_LINES];
  logic [`MOPC_LINES-1:0]   level_r;
  logic [`MOPC_LINES-1:0]   ovr_r;
  mopc_hold_t               hold_cnt_r [`MOPC_LINES];
  logic [31:0]              pre_r;
  logic                     tick_r;
  logic [`MOPC_LINES-1:0]   is_out;
  logic [`MOPC_LINES-1:0]   cfg_lvl;
  mopc_hold_t               hold_set [`MOPC_LINES];

  function automatic logic cfg_is_out(input mopc_cfg_t c);
    return (c == `MOPC_CFG_OUT_LOW) || (c == `MOPC_CFG_OUT_HIGH);
  endfunction : cfg_is_out

  // clamp protects against an oversized value from the controller
  function automatic mopc_hold_t hold_clamp(input mopc_hold_t h);
    return (h > `MOPC_HOLD_MAX) ? `MOPC_HOLD_MAX : h;
  endfunction : hold_clamp

  // free-running prescaler: a hold may lose up to one tick of its first period
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      pre_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (pre_r == TICK_CYCLES - 1) begin
      pre_r  <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      pre_r  <= pre_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MOPC_LINES; g++) begin : g_line
      if (g < `MOPC_GROUP_LINES) begin : g_lo
        assign hold_set[g] = hold_clamp(i_hold_timer_low_group[g]);
      end else begin : g_hi
        assign hold_set[g] = hold_clamp(i_hold_timer_high_group[g-`MOPC_GROUP_LINES]);
      end
      assign is_out[g]  = cfg_is_out(cfg_r[g]);
      assign cfg_lvl[g] = (cfg_r[g] == `MOPC_CFG_OUT_HIGH);

      always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
          cfg_r[g] <= `MOPC_CFG_DISABLED;
        end else if (i_cfg_we) begin
          cfg_r[g] <= i_line_cfg[g];
        end
      end

      always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
          ovr_r[g]      <= 1'b0;
          level_r[g]    <= 1'b0;
          hold_cnt_r[g] <= 13'h0000;
        end else if (i_cmd_valid && i_cmd.mask[g] && is_out[g]) begin
          level_r[g]    <= i_cmd.levels[g];
          ovr_r[g]      <= (i_cmd.levels[g] != cfg_lvl[g]);
          hold_cnt_r[g] <= hold_set[g];
        end else if (!is_out[g]) begin
          ovr_r[g]      <= 1'b0;
          level_r[g]    <= 1'b0;
          hold_cnt_r[g] <= 13'h0000;
        end else if (!ovr_r[g]) begin
          level_r[g]    <= cfg_lvl[g];
        end else if (tick_r && hold_cnt_r[g] != 13'h0000) begin
          hold_cnt_r[g] <= hold_cnt_r[g] - 13'h0001;
          if (hold_cnt_r[g] == 13'h0001) begin
            ovr_r[g]   <= 1'b0;
            level_r[g] <= cfg_lvl[g];
          end
        end
      end

      assign o_line_level[g] = level_r[g];
      assign o_line_oe[g]    = is_out[g];

      // command that hits this line: mask bit set and line drives
      sequence s_line_hit;
        i_cmd_valid && i_cmd.mask[g] && is_out[g];
      endsequence

      // final tick of a running hold with nothing else touching the line
      sequence s_last_tick;
        ovr_r[g] && is_out[g] && tick_r && hold_cnt_r[g] == 13'h0001 && !i_cmd_valid && !i_cfg_we;
      endsequence

      property p_revert_on_last_tick;
        @(posedge i_ref_clk) disable iff (!i_rstn)
          s_last_tick |=> (!ovr_r[g] && level_r[g] == cfg_lvl[g]);
      endproperty
      a_revert_on_last_tick: assert property (p_revert_on_last_tick) else $error("override did not revert");

      property p_hold_persist;
        @(posedge i_ref_clk) disable iff (!i_rstn)
          (ovr_r[g] && is_out[g] && hold_cnt_r[g] == 13'h0000 && !i_cmd_valid && !i_cfg_we)
          |=> (ovr_r[g] && $stable(level_r[g]));
      endproperty
      a_hold_persist: assert property (p_hold_persist) else $error("zero hold override lost");

      property p_unmasked_kept;
        @(posedge i_ref_clk) disable iff (!i_rstn)
          (i_cmd_valid && !i_cmd.mask[g] && ovr_r[g] && is_out[g] && !tick_r && !i_cfg_we)
          |=> $stable(level_r[g]);
      endproperty
      a_unmasked_kept: assert property (p_unmasked_kept) else $error("unmasked line changed");

      property p_same_level_clears;
        @(posedge i_ref_clk) disable iff (!i_rstn)
          s_line_hit ##0 (i_cmd.levels[g] == cfg_lvl[g]) |=> !ovr_r[g];
      endproperty
      a_same_level_clears: assert property (p_same_level_clears) else $error("same level kept override");

      // hold count comes from the group that owns this line
      property p_hold_loaded;
        @(posedge i_ref_clk) disable iff (!i_rstn)
          s_line_hit |=> (hold_cnt_r[g] == $past(hold_set[g]));
      endproperty
      a_hold_loaded: assert property (p_hold_loaded) else $error("hold count not loaded");

      property p_idle_line_low;
        @(posedge i_ref_clk) disable iff (!i_rstn)
          !is_out[g] |=> !level_r[g];
      endproperty
      a_idle_line_low: assert property (p_idle_line_low) else $error("non-output line driven high");
    end
  endgenerate

  // only driven lines count as active; input-only settings never start sampling
  logic any_active;
  assign any_active = |is_out;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_sample_enable  <= 1'b0;
      o_sample_to_mgmt <= 1'b0;
      o_sample_to_dest <= 1'b0;
    end else begin
      o_sample_enable  <= (i_sample_rate_setting != 16'h0000) && any_active;
      o_sample_to_mgmt <= (i_sample_rate_setting != 16'h0000) && any_active && i_mgmt_enable;
      o_sample_to_dest <= (i_sample_rate_setting != 16'h0000) && any_active && !i_mgmt_enable;
    end
  end

  sequence s_cmd_hit(int n);
    i_cmd_valid && i_cmd.mask[n] && is_out[n];
  endsequence

  property p_masked_write;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      s_cmd_hit(0) |=> (level_r[0] == $past(i_cmd.levels[0]));
  endproperty
  a_masked_write: assert property (p_masked_write) else $error("line level not taken");

  property p_tick_single;
    @(posedge i_ref_clk) disable iff (!i_rstn) tick_r |=> !tick_r;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick pulse longer than one cycle");

  property p_route_mgmt;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      ((i_sample_rate_setting != 16'h0000) && any_active && i_mgmt_enable) |=> o_sample_to_mgmt;
  endproperty
  a_route_mgmt: assert property (p_route_mgmt) else $error("samples not routed to management");

  property p_hold_bound;
    @(posedge i_ref_clk) disable iff (!i_rstn) hold_cnt_r[2] <= `MOPC_HOLD_MAX;
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("hold count above limit");

  property p_no_oe_after_reset;
    @(posedge i_ref_clk) $rose(i_rstn) |-> (o_line_oe == 20'h0_0000);
  endproperty
  a_no_oe_after_reset: assert property (p_no_oe_after_reset) else $error("output enabled after reset");

  property p_sample_gate;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_sample_rate_setting == 16'h0000) |=> !o_sample_enable;
  endproperty
  a_sample_gate: assert property (p_sample_gate) else $error("sampling with zero rate");

endmodule : mopc_top

// file: tb/mopc_host.sv
// host model issuing write-levels commands and hold settings
`timescale 1ns/10ps
module mopc_host
  import mopc_pkg::*;
(
  // clock
  input  wire logic i_ref_clk,
  // command and hold settings
  output logic       o_cmd_valid,
  output mopc_cmd_s  o_cmd,
  output mopc_hold_t o_hold_lo,
  output mopc_hold_t o_hold_hi
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd       = '0;
    o_hold_lo   = '0;
    o_hold_hi   = '0;
  end
  task automatic send(input logic [19:0] lv, input logic [19:0] mk, input mopc_hold_t hl, input mopc_hold_t hh);
    @(posedge i_ref_clk) #1;
    o_hold_lo   = (hl > 13'h1770) ? 13'h1770 : hl;
    o_hold_hi   = (hh > 13'h1770) ? 13'h1770 : hh;
    o_cmd       = '{levels: lv, mask: mk};
    o_cmd_valid = 1'b1;
    @(posedge i_ref_clk) #1;
    o_cmd_valid = 1'b0;
    // payload is stale once valid drops, so it is scrambled
    o_cmd       = ~o_cmd;
  endtask : send
endmodule : mopc_host

// file: tb/mopc_top_tb.sv
// self-checking bench for the masked output pin control block
`timescale 1ns/10ps
`include "mopc_params.svh"
module mopc_top_tb;
  import mopc_pkg::*;
  localparam int T = 10;
  logic        clk  = 1'b0;
  logic        rstn = 1'b0;
  logic        we, mg, cv, se, sm, sd;
  mopc_cfg_t   cfg [20];
  mopc_hold_t  hl, hh, hlo [10], hhi [10];
  logic [15:0] rate;
  mopc_cmd_s   cmd;
  logic [19:0] lvl, oe, outm, cl, cur, lv, mk;
  logic [42:0] q[$], exp;
  int          num_errors = 0, n_tests = 0, seed = 25794, k;
  always #10 clk = ~clk;
  for (genvar g = 0; g < 10; g++) begin : g_hold
    assign hlo[g] = hl;
    assign hhi[g] = hh;
  end
  mopc_host i_host (.i_ref_clk(clk), .o_cmd_valid(cv), .o_cmd(cmd), .o_hold_lo(hl), .o_hold_hi(hh));
  mopc_top #(.TICK_CYCLES(T)) i_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_line_cfg(cfg), .i_cfg_we(we),
    .i_hold_timer_low_group(hlo), .i_hold_timer_high_group(hhi), .i_cmd_valid(cv), .i_cmd(cmd),
    .i_sample_rate_setting(rate), .i_mgmt_enable(mg), .o_line_level(lvl), .o_line_oe(oe),
    .o_sample_enable(se), .o_sample_to_mgmt(sm), .o_sample_to_dest(sd));
  task automatic chk(input logic [2:0] s, input int n);
    repeat (n) @(posedge clk) #1;
    q.push_back({outm, cur & outm, s});
  endtask : chk
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  always @(negedge clk) if (q.size() > 0) begin
    exp = q.pop_front();
    n_tests++;
    if ({oe, lvl, se, sm, sd} !== exp) begin
      num_errors++;
      $display("CHECK FAILED outputs expected %h seen %h", exp, {oe, lvl, se, sm, sd});
    end
  end
  initial begin
    #(20 * 2000);
    num_errors++;
    finish_test();
  end
  initial begin
    foreach (cfg[i]) cfg[i] = 3'h0;
    {we, mg, rate, outm, cur} = '0;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    chk(3'b000, 0);
    for (int i = 0; i < 20; i++) begin
      k       = $unsigned($random(seed)) % 3;
      if (i == 0) k = 1 + (k % 2);
      cfg[i]  = (k == 0) ? 3'h0 : (k == 1) ? 3'h4 : 3'h5;
      outm[i] = (k != 0);
      cl[i]   = (k == 2);
    end
    we  = 1'b1;
    cur = cl;
    chk(3'b000, 2);
    we   = 1'b0;
    rate = 16'($random(seed)) | 16'h0001;
    mg   = 1'b1;
    chk(3'b110, 1);
    mg = 1'b0;
    chk(3'b101, 1);
    lv  = 20'($random(seed));
    mk  = 20'($random(seed));
    cur = (cur & ~mk) | (lv & mk);
    i_host.send(lv, mk, 13'h0000, 13'h0000);
    chk(3'b101, 0);
    chk(3'b101, 4 * T);
    cur = ~cl;
    i_host.send(~cl, 20'hF_FFFF, 13'h0002, 13'h0000);
    chk(3'b101, 0);
    chk(3'b101, T);
    cur = {~cl[19:10], cl[9:0]};
    chk(3'b101, 2 * T + 2);
    lv  = 20'($random(seed));
    cur = {cur[19:10], lv[9:0]};
    i_host.send(lv, 20'h0_03FF, 13'h0000, 13'h0000);
    chk(3'b101, 0);
    rstn = 1'b0;
    outm = '0;
    chk(3'b000, 1);
    rstn = 1'b1;
    i_host.send(20'hF_FFFF, 20'hF_FFFF, 13'h0000, 13'h0000);
    chk(3'b000, 1);
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule : mopc_top_tb
